/* File: src/sbs_pkg.sv */
// package: register map, defaults, timing and state type for the bring-up block
package sbs_pkg;
   // directly mapped register offsets
   localparam logic [7:0] REG_SOFT_RESET = 8'h01;
   localparam logic [7:0] REG_WDOG_SPEED = 8'h0a;
   localparam logic [7:0] REG_IND_PAGE = 8'hb0;
   localparam logic [7:0] REG_IND_ADDR = 8'hb1;
   localparam logic [7:0] REG_IND_DATA = 8'hb2;
   // analog space behind the indirect window
   localparam logic [7:0] ANA_PAGE = 8'h04;
   localparam logic [7:0] ANA_RAMP_ADAPT = 8'h4b;
   localparam logic [7:0] ANA_RAMP_FIXED = 8'h4c;
   // field positions
   localparam int SOFT_RESET_BIT = 0;
   localparam int RAMP_APPLY_BIT = 5;
   // reset values, not given for this device, so plain zeros
   localparam logic [7:0] RST_BYTE = 8'h00;
   // control-bus ready delay after enable rises
   localparam int READY_TIME_US = 2000;
   localparam int CLK_MHZ = 200;
   localparam int READY_CYCLES = READY_TIME_US * CLK_MHZ;
   localparam int CNT_W = 19;
   typedef enum logic {SBS_DOWN, SBS_UP} sbs_state_t;
   // all state of the sequencer
   typedef struct packed {
      logic en_s1, en_s2, hs_s1, hs_s2, bc_s1, bc_s2, sm_s1, sm_s2;
      sbs_state_t st;
      logic [CNT_W-1:0] rdy_cnt;
      logic ready, term_en, ref_bc, relock, lock_reinit, ramp_on;
      logic [7:0] wdog, page, iaddr, adapt, fixed, app_adapt, app_fixed;
      logic [7:0] rdata;
      logic rvalid;
   } sbs_regs_t;
endpackage

/* File: src/sbs_bringup.sv */
// serializer bring-up: enable handling, register file, indirect window
//
// Functional notes
// - termination switches on on entry to high-speed, off at burst end.
// - synchronous mode takes reference clock from the deserializer.
// - synchronous mode relocks onto back-channel clock once each time it appears.
// - analog registers reached via page, address and data window registers.
// - writing 0x01 to soft reset register applies updates, relocks link.
// - enable low powers down and returns all registers to defaults.
`timescale 1ns/10ps
module sbs_bringup #(
   parameter int READY_CYCLES = sbs_pkg::READY_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // device pins, asynchronous
   input wire logic chip_enable_pin,
   input wire logic lane_hs_request,
   input wire logic backchannel_clk_present,
   input wire logic sync_mode_strap,
   // register access from the control channel
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic reg_ready,
   // analog and link controls
   output logic lane_term_en,
   output logic ref_from_backchannel,
   output logic pll_relock,
   output logic link_lock_reinit,
   output logic [7:0] wdog_speed,
   output logic [7:0] ramp_adaptive,
   output logic [7:0] ramp_fixed,
   output logic ramp_adjust_on
);
   sbs_pkg::sbs_regs_t r, next_r;
   logic up, wr_ok, ana_sel;
   // counter width taken once here so the casts below stay short
   localparam int CW = sbs_pkg::CNT_W;

   // register file only answers once powered and past the ready delay
   assign up = r.en_s2 && (r.st == sbs_pkg::SBS_UP);
   assign wr_ok = up && r.ready && reg_wr;
   assign ana_sel = (r.page == sbs_pkg::ANA_PAGE);

   // next-state logic
   always_comb begin
      next_r = r;
      // pins pass two flops before use
      next_r.en_s1 = chip_enable_pin;
      next_r.en_s2 = r.en_s1;
      next_r.hs_s1 = lane_hs_request;
      next_r.hs_s2 = r.hs_s1;
      next_r.bc_s1 = backchannel_clk_present;
      next_r.bc_s2 = r.bc_s1;
      next_r.sm_s1 = sync_mode_strap;
      next_r.sm_s2 = r.sm_s1;
      next_r.relock = 1'b0;
      next_r.lock_reinit = 1'b0;
      next_r.rvalid = 1'b0;
      next_r.rdata = sbs_pkg::RST_BYTE;
      case (r.st)
         sbs_pkg::SBS_DOWN: begin
            // idle until the synchronised enable is high; registers
            // already hold their defaults from reset or power-down
            if (r.en_s2) begin
               next_r.st = sbs_pkg::SBS_UP;
            end
         end
         sbs_pkg::SBS_UP: begin
            // ready flag guards the host against early access
            if (!r.ready) begin
               if (r.rdy_cnt == CW'(READY_CYCLES - 1)) begin
                  next_r.ready = 1'b1;
               end else begin
                  next_r.rdy_cnt = r.rdy_cnt + 1'b1;
               end
            end
            // termination tracks the lane's high-speed phase
            next_r.term_en = r.hs_s2;
            // reference from deserializer in sync mode
            next_r.ref_bc = r.sm_s2 && r.bc_s2;
            if (r.sm_s2 && r.bc_s2 && !r.ref_bc) begin
               next_r.relock = 1'b1;
            end
            if (wr_ok) begin
               case (reg_addr)
                  sbs_pkg::REG_SOFT_RESET: begin
                     // self-clearing: apply staged analog values
                     if (reg_wdata[sbs_pkg::SOFT_RESET_BIT]) begin
                        next_r.lock_reinit = 1'b1;
                        next_r.app_adapt = r.adapt;
                        next_r.app_fixed = r.fixed;
                        next_r.ramp_on = r.adapt[sbs_pkg::RAMP_APPLY_BIT];
                     end
                  end
                  sbs_pkg::REG_WDOG_SPEED: next_r.wdog = reg_wdata;
                  sbs_pkg::REG_IND_PAGE: next_r.page = reg_wdata;
                  sbs_pkg::REG_IND_ADDR: next_r.iaddr = reg_wdata;
                  sbs_pkg::REG_IND_DATA: begin
                     // data writes land in the selected analog register
                     if (ana_sel && r.iaddr == sbs_pkg::ANA_RAMP_ADAPT) begin
                        next_r.adapt = reg_wdata;
                     end
                     if (ana_sel && r.iaddr == sbs_pkg::ANA_RAMP_FIXED) begin
                        next_r.fixed = reg_wdata;
                     end
                  end
                  default: ;
               endcase
            end
            // reads answer one cycle later; unmapped reads give zero
            if (up && r.ready && reg_rd) begin
               next_r.rvalid = 1'b1;
               case (reg_addr)
                  sbs_pkg::REG_WDOG_SPEED: next_r.rdata = r.wdog;
                  sbs_pkg::REG_IND_PAGE: next_r.rdata = r.page;
                  sbs_pkg::REG_IND_ADDR: next_r.rdata = r.iaddr;
                  sbs_pkg::REG_IND_DATA: begin
                     if (ana_sel && r.iaddr == sbs_pkg::ANA_RAMP_ADAPT) begin
                        next_r.rdata = r.adapt;
                     end else if (ana_sel &&
                                  r.iaddr == sbs_pkg::ANA_RAMP_FIXED) begin
                        next_r.rdata = r.fixed;
                     end
                  end
                  default: ;
               endcase
            end
            // enable low drops everything to defaults
            if (!r.en_s2) begin
               next_r = '0;
               next_r.en_s1 = chip_enable_pin;
               next_r.st = sbs_pkg::SBS_DOWN;
            end
         end
         default: next_r.st = sbs_pkg::SBS_DOWN;
      endcase
   end

   // single state register; reset gives all-zero defaults
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state flops
   assign reg_rdata = r.rdata;
   assign reg_rvalid = r.rvalid;
   assign reg_ready = r.ready;
   assign lane_term_en = r.term_en;
   assign ref_from_backchannel = r.ref_bc;
   assign pll_relock = r.relock;
   assign link_lock_reinit = r.lock_reinit;
   assign wdog_speed = r.wdog;
   assign ramp_adaptive = r.app_adapt;
   assign ramp_fixed = r.app_fixed;
   assign ramp_adjust_on = r.ramp_on;

   // sampled-value checks; one clock domain, quiet while in reset
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   term_on_hs_a: assert property (up && r.hs_s2 |=> lane_term_en)
      else $error("termination not on during high-speed");
   term_off_end_a: assert property (up && $fell(r.hs_s2) |-> ##1 !lane_term_en
      ##1 !lane_term_en || r.hs_s2)
      else $error("termination stayed on after burst");
   ref_sync_a: assert property (ref_from_backchannel |-> $past(r.sm_s2))
      else $error("back-channel reference outside sync mode");
   relock_rise_a: assert property (pll_relock |=> ref_from_backchannel)
      else $error("relock without back-channel reference");
   ready_time_a: assert property ($rose(reg_ready) |->
      r.rdy_cnt == CW'(READY_CYCLES - 1))
      else $error("ready flag raised early");
   soft_apply_a: assert property (wr_ok && reg_addr == sbs_pkg::REG_SOFT_RESET
      && reg_wdata[sbs_pkg::SOFT_RESET_BIT] |=> link_lock_reinit
      && ramp_adaptive == $past(r.adapt) ##1 !link_lock_reinit)
      else $error("soft reset did not apply staged values");
   ind_write_a: assert property (wr_ok && reg_addr == sbs_pkg::REG_IND_DATA
      && ana_sel && r.iaddr == sbs_pkg::ANA_RAMP_FIXED |=>
      r.fixed == $past(reg_wdata))
      else $error("indirect write lost");
   wdog_write_a: assert property (wr_ok && reg_addr == sbs_pkg::REG_WDOG_SPEED
      |=> wdog_speed == $past(reg_wdata))
      else $error("watchdog speed write lost");
   pd_clear_a: assert property (r.st == sbs_pkg::SBS_UP && !r.en_s2 |=>
      !reg_ready && wdog_speed == sbs_pkg::RST_BYTE && !ramp_adjust_on)
      else $error("power-down left register state");
   read_answer_a: assert property (up && r.ready && reg_rd |=> reg_rvalid
      ##1 !reg_rvalid || $past(reg_rd))
      else $error("read not answered in one cycle");
   // relock is a single-cycle request; a held one would restart the loop
   relock_pulse_a: assert property (pll_relock |=> !pll_relock)
      else $error("relock request held longer than one cycle");
   // the deserializer reference is only taken while its clock is there
   ref_needs_bc_a: assert property (ref_from_backchannel |->
      $past(r.bc_s2))
      else $error("back-channel reference without its clock");
   // a watchdog read returns the value held before the strobe edge
   wdog_read_a: assert property (up && r.ready && reg_rd &&
      reg_addr == sbs_pkg::REG_WDOG_SPEED |=>
      reg_rdata == $past(wdog_speed))
      else $error("watchdog read returned wrong value");

   cover_ready_c: cover property ($rose(reg_ready));
   cover_soft_c: cover property (link_lock_reinit && ramp_adjust_on);
   cover_relock_c: cover property (pll_relock);
   cover_pd_c: cover property (r.st == sbs_pkg::SBS_UP && !r.en_s2);
   cover_hs_c: cover property ($rose(lane_term_en) ##[1:20] !lane_term_en);
endmodule

/* File: verification/sbs_host_model.sv */
// host model: enable pin and register port as seen from the controller
`timescale 1ns/10ps
module sbs_host_model (
   // clock
   input wire logic sys_clk,
   // pin and register port driven by the host
   output logic chip_enable_pin,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   // read answer
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   // supply taken as stable from time zero, so enable may rise at once
   initial begin
      chip_enable_pin = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // one write; idle lines flip so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // one read; answer is taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(negedge sys_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge sys_clk);
      d = reg_rdata;
      v = reg_rvalid;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask
   // raise enable; the main supply counts as stable from time zero
   task automatic power_up();
      chip_enable_pin = 1'b1;
   endtask
   // low pulse on enable, high time already served by the caller
   task automatic hard_reset(input int cyc);
      @(negedge sys_clk);
      chip_enable_pin = 1'b0;
      repeat (cyc) @(negedge sys_clk);
      chip_enable_pin = 1'b1;
   endtask
   // adaptive ramp offset by die temperature code
   function automatic logic [7:0] offs(input logic [2:0] code);
      if (code == 3'd1) return 8'hff;
      if (code >= 3'd4) return 8'h01;
      return 8'h00;
   endfunction
endmodule

/* File: verification/serializer_bringup_sequencer_tb.sv */
// testbench for the bring-up block with a host model on its far side
`timescale 1ns/10ps
module serializer_bringup_sequencer_tb;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic lane_hs_request = 1'b0;
   logic backchannel_clk_present = 1'b0;
   logic sync_mode_strap = 1'b0;
   logic chip_enable_pin, reg_wr, reg_rd, reg_rvalid, reg_ready, v;
   logic lane_term_en, ref_from_backchannel, pll_relock, link_lock_reinit;
   logic ramp_adjust_on;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, wdog_speed, ramp_adaptive;
   logic [7:0] ramp_fixed, d, ad_sh = 8'h00, fx_sh = 8'h00;
   int n_mismatch = 0;
   int cmp_count = 0;
   always #2.5 sys_clk = ~sys_clk;
   sbs_bringup #(.READY_CYCLES(16)) uut (.sys_clk(sys_clk), .srst(srst),
      .chip_enable_pin(chip_enable_pin), .lane_hs_request(lane_hs_request),
      .backchannel_clk_present(backchannel_clk_present),
      .sync_mode_strap(sync_mode_strap), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .reg_ready(reg_ready),
      .lane_term_en(lane_term_en),
      .ref_from_backchannel(ref_from_backchannel), .pll_relock(pll_relock),
      .link_lock_reinit(link_lock_reinit), .wdog_speed(wdog_speed),
      .ramp_adaptive(ramp_adaptive), .ramp_fixed(ramp_fixed),
      .ramp_adjust_on(ramp_adjust_on));
   sbs_host_model host (.sys_clk(sys_clk),
      .chip_enable_pin(chip_enable_pin), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 40 && reg_ready !== 1'b1; i++) @(negedge sys_clk);
      check(reg_ready, 1'b1);
   endtask
   // writes before the bus is ready must be dropped
   task automatic t_early();
      host.power_up();
      check(reg_ready, 1'b0);
      host.wr(sbs_pkg::REG_WDOG_SPEED, 8'h55);
      wait_ready();
      check(wdog_speed, 8'h00);
   endtask
   // watchdog speed-up, self-clearing and unmapped reads
   task automatic t_wdog();
      host.wr(sbs_pkg::REG_WDOG_SPEED, 8'h12);
      check(wdog_speed, 8'h12);
      host.rd(sbs_pkg::REG_WDOG_SPEED, d, v);
      check({v, d}, 9'h112);
      host.rd(sbs_pkg::REG_SOFT_RESET, d, v);
      check({v, d}, 9'h100);
      host.rd(8'h55, d, v);
      check({v, d}, 9'h100);
   endtask
   // full ramp setup through the window, then soft reset applies it
   task automatic t_ramp(input logic [2:0] code);
      host.wr(sbs_pkg::REG_IND_PAGE, sbs_pkg::ANA_PAGE);
      host.wr(sbs_pkg::REG_IND_ADDR, sbs_pkg::ANA_RAMP_FIXED);
      host.rd(sbs_pkg::REG_IND_DATA, d, v);
      check(d, fx_sh);
      fx_sh = (fx_sh & 8'h8f) | 8'h70;
      host.wr(sbs_pkg::REG_IND_DATA, fx_sh);
      host.wr(sbs_pkg::REG_IND_ADDR, sbs_pkg::ANA_RAMP_ADAPT);
      host.rd(sbs_pkg::REG_IND_DATA, d, v);
      check(d, ad_sh);
      ad_sh = (ad_sh | 8'h20) + host.offs(code);
      host.wr(sbs_pkg::REG_IND_DATA, ad_sh);
      host.wr(sbs_pkg::REG_SOFT_RESET, 8'h01);
      check(link_lock_reinit, 1'b1);
      check(ramp_fixed, fx_sh);
      check(ramp_adaptive, ad_sh);
      check(ramp_adjust_on, ad_sh[5]);
      @(negedge sys_clk);
      check(link_lock_reinit, 1'b0);
   endtask
   // termination follows the high-speed phase
   task automatic t_term();
      lane_hs_request = 1'b1;
      repeat (4) @(negedge sys_clk);
      check(lane_term_en, 1'b1);
      lane_hs_request = 1'b0;
      repeat (4) @(negedge sys_clk);
      check(lane_term_en, 1'b0);
   endtask
   // relock onto the back-channel clock in synchronous mode
   task automatic t_sync();
      logic seen;
      seen = 1'b0;
      backchannel_clk_present = 1'b1;
      repeat (6) begin
         @(negedge sys_clk);
         seen = seen | pll_relock;
      end
      check({seen, ref_from_backchannel}, 2'b00);
      sync_mode_strap = 1'b1;
      repeat (6) begin
         @(negedge sys_clk);
         seen = seen | pll_relock;
      end
      check(seen, 1'b1);
      check(ref_from_backchannel, 1'b1);
      backchannel_clk_present = 1'b0;
      repeat (4) @(negedge sys_clk);
      check(ref_from_backchannel, 1'b0);
      seen = 1'b0;
      backchannel_clk_present = 1'b1;
      repeat (6) begin
         @(negedge sys_clk);
         seen = seen | pll_relock;
      end
      check(seen, 1'b1);
   endtask
   // enable low clears ready, watchdog speed and fixed ramp back to default
   task automatic t_pdown();
      fork
         host.hard_reset(12);
         begin
            repeat (8) @(negedge sys_clk);
            check({reg_ready, wdog_speed, ramp_fixed}, 17'h0);
         end
      join
      wait_ready();
      host.rd(sbs_pkg::REG_WDOG_SPEED, d, v);
      check(d, 8'h00);
   endtask
   task automatic tally_and_finish();
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge sys_clk);
      srst = 1'b0;
      t_early();
      t_wdog();
      for (int c = 1; c < 7; c++) t_ramp(3'(c));
      t_term();
      t_sync();
      t_pdown();
      tally_and_finish();
   end
   // whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
